/* File: hw/eeprom_pkg.sv */
// Constants, types and timing shared by the serial memory target.
package eeprom_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int MEM_WORDS = 256;
    localparam int OFS_W = 3;
    localparam int FIFO_DEPTH = 16;
    localparam logic [6:0] DEV_ADDR = 7'h50;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_END = 4'h9;
    localparam int CLK_HZ = 50000000;
    localparam int T_WR_MS = 5;
    localparam int WR_CYCLES = T_WR_MS * (CLK_HZ / 1000);
    localparam int WR_CNT_W = 18;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } wr_entry_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEV = 3'b001,
        ST_WORD = 3'b010,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b100
    } phase_t;
endpackage

/* File: hw/wr_fifo.sv */
// Small synchronous FIFO holding address and data pairs waiting to be programmed.
module wr_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [PTR_W:0] count_r;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;

    assign in_ready_o = count_r != (PTR_W+1)'(DEPTH);
    assign out_valid_o = count_r != '0;
    assign out_data_o = store[rd_ptr_r];

    always_ff @(posedge clock_i) begin
        if (push) begin
            store[wr_ptr_r] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            wr_ptr_r <= push ? PTR_W'(wr_ptr_r + 1'b1) : wr_ptr_r;
            rd_ptr_r <= pop ? PTR_W'(rd_ptr_r + 1'b1) : rd_ptr_r;
            count_r <= (PTR_W+1)'(count_r + push - pop);
        end
    end
endmodule

/* File: hw/serial_eeprom_target.sv */
// Two-wire serial memory target: bus decoder, byte array and self-timed programming.
module serial_eeprom_target #(
    parameter int WR_CYCLES = eeprom_pkg::WR_CYCLES
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Two-wire bus
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Straps and protection
    input wire logic [2:0] unused_strap_pins_i,
    input wire logic wp_i,
    // Status
    output logic write_busy_o
);
    // Pin synchronisers: index 2 is SCL, 1 is SDA, 0 is write protect.
    logic [2:0] sync_a_r;
    logic [2:0] sync_b_r;
    logic scl_q_r;
    logic sda_q_r;

    eeprom_pkg::phase_t state_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic [eeprom_pkg::ADDR_W-1:0] addr_r;
    logic sda_oe_r;
    logic is_read_r;
    logic mnack_r;
    logic wr_pend_r;
    logic busy_r;
    logic [eeprom_pkg::WR_CNT_W-1:0] wr_cnt_r;

    logic [eeprom_pkg::DATA_W-1:0] mem [eeprom_pkg::MEM_WORDS];

    eeprom_pkg::wr_entry_t fifo_in;
    eeprom_pkg::wr_entry_t fifo_out;
    logic fifo_in_ready;
    logic fifo_out_valid;

    wire scl_s = sync_b_r[2];
    wire sda_s = sync_b_r[1];
    wire wp_s = sync_b_r[0];
    wire scl_rise = scl_s && !scl_q_r;
    wire scl_fall = !scl_s && scl_q_r;
    wire start_det = scl_s && scl_q_r && sda_q_r && !sda_s;
    wire stop_det = scl_s && scl_q_r && !sda_q_r && sda_s;
    wire in_ack_slot = scl_fall && (bit_cnt_r == eeprom_pkg::BIT_ACK);
    wire ack_end = scl_fall && (bit_cnt_r == eeprom_pkg::BIT_END);
    // The strap pins take no part in the match, so one fixed address answers.
    wire dev_match = shift_r[7:1] == eeprom_pkg::DEV_ADDR;
    // Address polling: the target stays silent while it programs.
    wire dev_ack = dev_match && !busy_r;
    // A protected byte is acknowledged but never queued.
    wire data_ack = wp_s || fifo_in_ready;
    wire is_dev = state_r == eeprom_pkg::ST_DEV;
    wire is_word = state_r == eeprom_pkg::ST_WORD;
    wire is_wdata = state_r == eeprom_pkg::ST_WDATA;
    wire is_rdata = state_r == eeprom_pkg::ST_RDATA;
    wire push = in_ack_slot && is_wdata && !wp_s && fifo_in_ready;
    wire ack_now = in_ack_slot && ((is_dev && dev_ack) || is_word || (is_wdata && data_ack));
    wire [7:0] rd_byte = mem[addr_r];
    // Page writes wrap inside their 8-byte page; reads walk the whole array.
    wire [eeprom_pkg::ADDR_W-1:0] page_next = {addr_r[eeprom_pkg::ADDR_W-1:eeprom_pkg::OFS_W],
        eeprom_pkg::OFS_W'(addr_r[eeprom_pkg::OFS_W-1:0] + 1'b1)};
    wire [eeprom_pkg::ADDR_W-1:0] addr_inc = eeprom_pkg::ADDR_W'(addr_r + 1'b1);
    wire [eeprom_pkg::WR_CNT_W-1:0] cnt_last = eeprom_pkg::WR_CNT_W'(WR_CYCLES - 1);
    wire cnt_done = wr_cnt_r == cnt_last;
    wire start_prog = stop_det && wr_pend_r && fifo_out_valid && !busy_r;
    wire pop = busy_r && fifo_out_valid;

    assign fifo_in = '{addr: addr_r, data: shift_r};
    assign sda_o = 1'b0;
    assign sda_oe_o = sda_oe_r;
    assign write_busy_o = busy_r;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_a_r <= 3'h7;
            sync_b_r <= 3'h7;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            sync_a_r <= {scl_i, sda_i, wp_i};
            sync_b_r <= sync_a_r;
            scl_q_r <= scl_s;
            sda_q_r <= sda_s;
        end
    end

    // Byte engine. Inputs shift on SCL rise, SDA drive moves on SCL fall and is also released at a start or stop.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= eeprom_pkg::ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            addr_r <= 8'h00;
            sda_oe_r <= 1'b0;
            is_read_r <= 1'b0;
            mnack_r <= 1'b1;
            wr_pend_r <= 1'b0;
        end else if (start_det) begin
            state_r <= eeprom_pkg::ST_DEV;
            bit_cnt_r <= 4'h0;
            sda_oe_r <= 1'b0;
        end else if (stop_det) begin
            state_r <= eeprom_pkg::ST_IDLE;
            bit_cnt_r <= 4'h0;
            sda_oe_r <= 1'b0;
            wr_pend_r <= 1'b0;
        end else if (state_r != eeprom_pkg::ST_IDLE) begin
            if (scl_rise) begin
                bit_cnt_r <= 4'(bit_cnt_r + 1'b1);
                if (!is_rdata) begin
                    shift_r <= {shift_r[6:0], sda_s};
                end else if (bit_cnt_r == eeprom_pkg::BIT_ACK) begin
                    mnack_r <= sda_s;
                end
            end else if (in_ack_slot) begin
                sda_oe_r <= ack_now;
                if (is_dev) begin
                    is_read_r <= shift_r[0];
                    if (!dev_ack) begin
                        state_r <= eeprom_pkg::ST_IDLE;
                    end
                end
                if (is_word) begin
                    addr_r <= shift_r;
                end
                if (is_wdata) begin
                    addr_r <= page_next;
                    wr_pend_r <= wr_pend_r || push;
                end
            end else if (ack_end) begin
                bit_cnt_r <= 4'h0;
                sda_oe_r <= 1'b0;
                case (state_r)
                    eeprom_pkg::ST_DEV: begin
                        if (is_read_r) begin
                            state_r <= eeprom_pkg::ST_RDATA;
                            tx_r <= rd_byte;
                            sda_oe_r <= !rd_byte[7];
                            addr_r <= addr_inc;
                        end else begin
                            state_r <= eeprom_pkg::ST_WORD;
                        end
                    end
                    eeprom_pkg::ST_WORD: begin
                        state_r <= eeprom_pkg::ST_WDATA;
                    end
                    eeprom_pkg::ST_RDATA: begin
                        if (!mnack_r) begin
                            tx_r <= rd_byte;
                            sda_oe_r <= !rd_byte[7];
                            addr_r <= addr_inc;
                        end else begin
                            state_r <= eeprom_pkg::ST_IDLE;
                        end
                    end
                    default: begin
                        state_r <= state_r;
                    end
                endcase
            end else if (scl_fall && is_rdata) begin
                tx_r <= {tx_r[6:0], 1'b0};
                sda_oe_r <= !tx_r[6];
            end
        end
    end

    // Self-timed write: the FIFO drains into the array while the timer runs out.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_r <= 1'b0;
            wr_cnt_r <= '0;
        end else if (start_prog) begin
            busy_r <= 1'b1;
            wr_cnt_r <= '0;
        end else if (busy_r) begin
            if (!cnt_done) begin
                wr_cnt_r <= eeprom_pkg::WR_CNT_W'(wr_cnt_r + 1'b1);
            end else if (!fifo_out_valid) begin
                busy_r <= 1'b0;
            end
        end
    end

    // The array is nonvolatile, so it has no reset.
    always_ff @(posedge clock_i) begin
        if (pop) begin
            mem[fifo_out.addr] <= fifo_out.data;
        end
    end

    wr_fifo #(
        .WIDTH($bits(eeprom_pkg::wr_entry_t)),
        .DEPTH(eeprom_pkg::FIFO_DEPTH)
    ) u_wr_fifo (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(push),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(busy_r),
        .out_data_o(fifo_out)
    );

    property p_oe_after_fall;
        @(posedge clock_i) disable iff (!rst_n_i)
        $rose(sda_oe_r) |-> $past(scl_fall);
    endproperty
    a_oe_after_fall: assert property (p_oe_after_fall) else $error("SDA pulled off a falling edge");

    property p_open_drain;
        @(posedge clock_i) disable iff (!rst_n_i)
        sda_oe_o |-> (sda_o == 1'b0) && state_r != eeprom_pkg::ST_IDLE;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("SDA driven high");

    property p_word_ack;
        @(posedge clock_i) disable iff (!rst_n_i)
        (in_ack_slot && is_word && !start_det && !stop_det) |=> sda_oe_r;
    endproperty
    a_word_ack: assert property (p_word_ack) else $error("Word address not acknowledged");

    property p_dev_nack;
        @(posedge clock_i) disable iff (!rst_n_i)
        (in_ack_slot && is_dev && !dev_match && !start_det && !stop_det)
            |=> !sda_oe_r && state_r == eeprom_pkg::ST_IDLE;
    endproperty
    a_dev_nack: assert property (p_dev_nack) else $error("Foreign address acknowledged");

    // A protected byte must leave both the commit flag and the queue untouched.
    property p_wp_no_queue;
        @(posedge clock_i) disable iff (!rst_n_i)
        (in_ack_slot && is_wdata && wp_s && !start_det && !stop_det)
            |=> $stable(wr_pend_r) && $stable(fifo_out_valid);
    endproperty
    a_wp_no_queue: assert property (p_wp_no_queue) else $error("Protected byte queued");

    property p_wp_ack;
        @(posedge clock_i) disable iff (!rst_n_i)
        (in_ack_slot && is_wdata && wp_s && !start_det && !stop_det) |=> sda_oe_r;
    endproperty
    a_wp_ack: assert property (p_wp_ack) else $error("Protected byte not acknowledged");

    property p_page_wrap;
        @(posedge clock_i) disable iff (!rst_n_i)
        push |=> addr_r[7:3] == $past(addr_r[7:3]) && addr_r[2:0] == 3'($past(addr_r[2:0]) + 1'b1);
    endproperty
    a_page_wrap: assert property (p_page_wrap) else $error("Page write left its page");

    property p_prog_start;
        @(posedge clock_i) disable iff (!rst_n_i)
        start_prog |=> busy_r && wr_cnt_r == '0;
    endproperty
    a_prog_start: assert property (p_prog_start) else $error("Programming did not start at stop");

    property p_prog_bound;
        @(posedge clock_i) disable iff (!rst_n_i)
        busy_r |-> wr_cnt_r <= cnt_last;
    endproperty
    a_prog_bound: assert property (p_prog_bound) else $error("Write cycle overran");

    c_page_write: cover property (@(posedge clock_i) disable iff (!rst_n_i) start_prog);
    c_read_byte: cover property (@(posedge clock_i) disable iff (!rst_n_i) ack_end && is_rdata);
    c_wp_block: cover property (@(posedge clock_i) disable iff (!rst_n_i) in_ack_slot && is_wdata && wp_s);
endmodule

/* File: tb/bus_ctl_model.sv */
// Behavioural two-wire bus controller that drives SCL and pulls SDA low.
module bus_ctl_model (
    // Clock
    input wire logic clock_i,
    // Bus
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask

    // Each SCL half is four system clocks, giving the 160 ns link period.
    // SDA moves one clock after SCL falls so the target never sees it as a start or stop.
    task automatic bit_io(input logic tx, output logic rx);
        tick(1);
        sda_oe_o <= ~tx;
        tick(3);
        scl_o <= 1'b1;
        tick(4);
        rx = sda_i;
        scl_o <= 1'b0;
    endtask

    task automatic start_cond();
        tick(1);
        sda_oe_o <= 1'b0;
        tick(3);
        scl_o <= 1'b1;
        tick(4);
        sda_oe_o <= 1'b1;
        tick(4);
        scl_o <= 1'b0;
    endtask

    task automatic stop_cond();
        tick(1);
        sda_oe_o <= 1'b1;
        tick(3);
        scl_o <= 1'b1;
        tick(4);
        sda_oe_o <= 1'b0;
        tick(4);
    endtask

    task automatic xfer(input logic [7:0] tx, input logic b9, output logic [7:0] rx,
                        output logic b9r);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(b9, b9r);
    endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the serial memory target with a byte-array reference model.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int WR_CYC = 200;
    logic clock = 1'b0;
    logic rst_n;
    logic [2:0] straps;
    logic wp;
    logic dut_sda;
    logic dut_oe;
    logic busy;
    logic ctl_oe;
    logic [7:0] a;
    wire logic scl;
    wire logic sda;
    int err_total = 0;
    int total_checks = 0;
    logic [7:0] mem_m [256];
    int ptr_m;

    // SDA has a pull-up: it is low only while some party pulls it.
    assign sda = !((dut_oe && !dut_sda) || ctl_oe);

    always #10 clock = ~clock;

    serial_eeprom_target #(.WR_CYCLES(WR_CYC)) dut (.clock_i(clock), .rst_n_i(rst_n),
        .scl_i(scl), .sda_i(sda), .sda_o(dut_sda), .sda_oe_o(dut_oe),
        .unused_strap_pins_i(straps), .wp_i(wp), .write_busy_o(busy));
    bus_ctl_model ctl (.clock_i(clock), .sda_i(sda), .scl_o(scl), .sda_oe_o(ctl_oe));

    task automatic stop_test();
        if (err_total == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic addr_phase(input logic [7:0] dev, input logic exp_ack);
        logic [7:0] rx;
        logic b;
        ctl.start_cond();
        ctl.xfer(dev, 1'b1, rx, b);
        chk("device ack", {7'h00, exp_ack}, {7'h00, ~b});
    endtask

    // The programming time is bounded, so a busy flag that never drops ends the run.
    task automatic wait_idle();
        int c;
        c = 0;
        while (busy !== 1'b0 && c < WR_CYC + 10) begin
            ctl.tick(1);
            c++;
        end
        if (c >= WR_CYC + 10) begin
            err_total++;
            $display("[FAIL] busy expected 0 seen %b", busy);
            stop_test();
        end
    endtask

    task automatic wr(input logic [7:0] adr, input int n, input logic prot);
        logic [7:0] rx;
        logic [7:0] d;
        logic b;
        addr_phase(8'hA0, 1'b1);
        ctl.xfer(adr, 1'b1, rx, b);
        chk("word ack", 8'h01, {7'h00, ~b});
        for (int k = 0; k < n; k++) begin
            d = 8'($urandom);
            ctl.xfer(d, 1'b1, rx, b);
            chk("data ack", 8'h01, {7'h00, ~b});
            if (!prot) mem_m[{adr[7:3], 3'(adr[2:0] + 3'(k))}] = d;
        end
        ctl.stop_cond();
        ctl.tick(2);
        chk("busy", {7'h00, ~prot}, {7'h00, busy});
        if (!prot) begin
            addr_phase(8'hA0, 1'b0);
            ctl.stop_cond();
        end
        wait_idle();
    endtask

    task automatic rd(input logic [7:0] adr, input int n, input logic set_addr);
        logic [7:0] rx;
        logic b;
        if (set_addr) begin
            addr_phase(8'hA0, 1'b1);
            ctl.xfer(adr, 1'b1, rx, b);
            ptr_m = adr;
        end
        addr_phase(8'hA1, 1'b1);
        for (int k = 0; k < n; k++) begin
            ctl.xfer(8'hFF, (k == n - 1), rx, b);
            chk("read data", mem_m[ptr_m], rx);
            ptr_m = (ptr_m + 1) % 256;
        end
        ctl.stop_cond();
    endtask

    initial begin
        rst_n = 1'b0;
        wp = 1'b0;
        straps = 3'h0;
        ptr_m = 0;
        void'($urandom(32'h0B75));
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        straps <= 3'($urandom);
        ctl.tick(4);
        wr(8'h25, 10, 1'b0);
        wr(8'h28, 3, 1'b0);
        a = 8'h30 + 8'($urandom_range(207));
        wr(a, 1, 1'b0);
        rd(a, 1, 1'b1);
        wp <= 1'b1;
        wr(8'h22, 2, 1'b1);
        wp <= 1'b0;
        rd(8'h20, 10, 1'b1);
        rd(8'h00, 1, 1'b0);
        straps <= ~straps;
        addr_phase(8'hA0, 1'b1);
        ctl.stop_cond();
        addr_phase(8'hA2, 1'b0);
        ctl.stop_cond();
        stop_test();
    end
endmodule
